// ---- core/ovsc_pkg.sv ----
// Constants shared by the overlay scaler control register bank
package ovsc_pkg;

    // ----------
    // Register byte offsets inside the control aperture
    // ----------
    localparam int          ADDR_W          = 14;
    localparam logic [13:0] OFS_B1_ORG      = 14'h3D08;
    localparam logic [13:0] OFS_B2_ORG      = 14'h3D0C;
    localparam logic [13:0] OFS_B2_CORG     = 14'h3D1C;
    localparam logic [13:0] OFS_CTRL        = 14'h3D20;
    localparam logic [13:0] OFS_HEDGES      = 14'h3D28;
    localparam logic [13:0] OFS_HISCAL      = 14'h3D30;
    localparam logic [13:0] OFS_GLOBAL      = 14'h3DC0;

    // ----------
    // Field layouts
    // ----------
    localparam int          ORG_W           = 24;
    localparam int          EDGE_W          = 11;
    localparam int          RIGHT_LSB       = 0;
    localparam int          LEFT_LSB        = 16;
    localparam int          HISCAL_W        = 19;
    localparam int          HISCAL_LSB      = 2;
    localparam int          VCNT_W          = 12;
    localparam int          VCNT_LSB        = 16;

    // Control word bits
    localparam int          CB_ENABLE       = 0;
    localparam int          CB_F1_PAR       = 6;
    localparam int          CB_F2_PAR       = 7;
    localparam int          CB_HFILT        = 10;
    localparam int          CB_VFILT        = 11;
    localparam int          CB_HFIX         = 12;
    localparam int          CB_CUPS         = 16;
    localparam int          CB_PLANAR       = 17;
    localparam int          CB_DITHER       = 18;
    localparam int          CB_MIRROR       = 19;
    localparam int          CB_BW           = 20;
    localparam int          CB_BLANK        = 21;
    localparam int          CB_FSELM        = 24;
    localparam int          CB_FSEL_LSB     = 25;
    localparam logic [31:0] CTRL_MASK       = 32'h073F1CC1;
    localparam logic [31:0] CTRL_RESET      = 32'h00000000;

    // Global control bits
    localparam int          GB_ZOOM         = 0;
    localparam int          GB_ZOOMF        = 1;
    localparam int          GB_CORDER       = 3;
    localparam int          GB_HUPD         = 4;
    localparam logic [31:0] GLOB_MASK       = 32'h0000001B;
    localparam logic [31:0] GLOB_RESET      = 32'h00000000;

    // ----------
    // Values
    // ----------
    localparam logic [18:0] HISCAL_UNITY    = 19'h04000;
    localparam logic [13:0] HALF_WEIGHT     = 14'h2000;
    localparam logic [7:0]  CHROMA_MID      = 8'h80;

    // Displayed buffer and field
    typedef enum logic [1:0] {
        SEL_A_F1 = 2'b00,
        SEL_A_F2 = 2'b01,
        SEL_B_F1 = 2'b10,
        SEL_B_F2 = 2'b11
    } ovsc_sel_t;

endpackage : ovsc_pkg

// ---- core/ovsc_regs.sv ----
// Overlay scaler control register bank
//
// Contract
// [RQ1] Buffer B origins hold 24-bit byte addresses
// [RQ2] Software aligns origins 000, or 111 mirrored
// [RQ3] Planar mode uses luma and chroma origins
// [RQ4] Control bit 0 enables the scaler
// [RQ5] Bits 6,7 give field start line parity
// [RQ6] Bit 10 interpolates horizontally only when scaling
// [RQ7] Bit 11 interpolates vertically only when scaling
// [RQ8] Bit 12 forces horizontal weight one half
// [RQ9] Bit 16 upsamples chroma with half coefficient
// [RQ10] Bit 17 selects 4:2:2 or planar 4:2:0
// [RQ11] Bit 18 enables output dithering
// [RQ12] Bit 19 reads lines with descending addresses
// [RQ13] Bit 20 forces both chromas to 128
// [RQ14] Bit 21 blanks the window to black
// [RQ15] Bit 24 picks software or hardware field
// [RQ16] Bits 26:25 pick displayed buffer and field
// [RQ17] Global bits 0,1 give 2x zoom, interpolated
// [RQ18] Global bit 3 swaps planar chroma byte order
// [RQ19] Global bit 4 loads at line, not retrace
// [RQ20] Global bits 27:16 show vertical counter
// [RQ21] Software keeps left edge below right edge
// [RQ22] Inverse horizontal scale is 5.14 in 20:2
`timescale 1ns/1ps
module ovsc_regs
    import ovsc_pkg::*;
(
    input  wire logic                ref_clk,         // 10 MHz clock
    input  wire logic                rst,             // Async reset, high
    // Memory mapped access
    input  wire logic [ADDR_W-1:0]   regAddr,         // Byte offset in aperture
    input  wire logic                regWr,           // Write strobe
    input  wire logic                regRd,           // Read strobe
    input  wire logic [3:0]          regBe,           // Byte enables
    input  wire logic [31:0]         regWdata,        // Write data
    output logic      [31:0]         regRdata,        // Read data
    output logic                     regRdValid,      // Read data valid
    // Display timing pins
    input  wire logic                vsyncPin,        // Vertical retrace
    input  wire logic                hsyncPin,        // Horizontal sync
    input  wire logic                vipFieldPin,     // Video input field
    input  wire logic                vipBufPin,       // Video input buffer
    input  wire logic                vertScaling,     // Vertical scale not unity
    // Scaler controls
    output logic                     scalerOn,        // Scaler enabled
    output logic                     firstFieldStartParity,  // Field 1 odd start
    output logic                     secondFieldStartParity, // Field 2 odd start
    output logic                     hInterp,         // Horizontal interpolation
    output logic                     vInterp,         // Vertical interpolation
    output logic                     hWeightFixed,    // Use fixed half weight
    output logic      [13:0]         hWeightFixedVal, // The fixed weight
    output logic                     chromaUpsample,  // Chroma upsampling
    output logic                     two_plane_format,// Planar 4:2:0 source
    output logic                     ditherOn,        // Output dithering
    output logic                     readDescending,  // Mirrored fetch
    output logic                     chromaForce,     // Black and white
    output logic      [7:0]          chromaForceVal,  // Forced chroma value
    output logic                     blankWindow,     // Show black
    output logic                     hwFieldSelect,   // Hardware field select
    output ovsc_sel_t                dispSel,         // Displayed buffer, field
    output logic                     zoom2x,          // 2x horizontal zoom
    output logic                     zoom2xInterp,    // Interpolate zoom pixels
    output logic                     chromaSwap,      // Cb in odd bytes
    output logic      [ORG_W-1:0]    lumaOrigin,      // First pixel address
    output logic                     lumaOriginValid, // Buffer B shown
    output logic      [ORG_W-1:0]    chromaOrigin,    // Chroma plane address
    output logic                     chromaOriginValid, // Planar B field 2
    output logic      [EDGE_W-1:0]   winLeft,         // Window left edge
    output logic      [EDGE_W-1:0]   winRight,        // Window right edge
    output logic      [HISCAL_W-1:0] hInvScale,       // Source step per pixel
    output logic      [VCNT_W-1:0]   vCountOut        // Vertical position
);

    // ----------
    // Helper functions
    // ----------
    function automatic logic hit(input logic [13:0] a, input logic [13:0] ofs);
        hit = (a[13:2] == ofs[13:2]);
    endfunction : hit

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge = res;
    endfunction : merge

    // ----------
    // Storage
    // ----------
    logic [ORG_W-1:0]    orgB1Pend_r;
    logic [ORG_W-1:0]    orgB2Pend_r;
    logic [ORG_W-1:0]    corgB2Pend_r;
    logic [31:0]         ctrlPend_r;
    logic [31:0]         edgesPend_r;
    logic [HISCAL_W-1:0] hiscalPend_r;
    logic [31:0]         glob_r;
    logic [ORG_W-1:0]    orgB1_r;
    logic [ORG_W-1:0]    orgB2_r;
    logic [ORG_W-1:0]    corgB2_r;
    logic [31:0]         ctrl_r;
    logic [31:0]         edges_r;
    logic [HISCAL_W-1:0] hiscal_r;
    ovsc_sel_t           dispSel_r;
    logic [31:0]         rdata_r;
    logic                rdValid_r;
    logic [31:0]         hiscalWord;
    logic [31:0]         rdata_nxt;
    logic [ORG_W-1:0]    lumaOrg_r;
    logic                lumaOrgValid_r;
    logic                chromaOrgValid_r;
    logic                hInterp_r;
    logic                vInterp_r;

    ovsc_tim_if tif ();

    ovsc_timing u_timing (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .vsyncPin    (vsyncPin),
        .hsyncPin    (hsyncPin),
        .vipFieldPin (vipFieldPin),
        .vipBufPin   (vipBufPin),
        .tim         (tif.tim)
    );

    assign tif.hupMode = glob_r[GB_HUPD];
    assign hiscalWord  = {11'h000, hiscalPend_r, 2'b00};

    // ----------
    // Host writes to pending copies
    // ----------
    // [RQ1] origin words, 24 bits kept
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            orgB1Pend_r  <= '0;
            orgB2Pend_r  <= '0;
            corgB2Pend_r <= '0;
        end else if (regWr) begin
            if (hit(regAddr, OFS_B1_ORG)) begin
                orgB1Pend_r <= merge({8'h00, orgB1Pend_r}, regWdata, regBe)
                               [ORG_W-1:0];
            end
            if (hit(regAddr, OFS_B2_ORG)) begin
                orgB2Pend_r <= merge({8'h00, orgB2Pend_r}, regWdata, regBe)
                               [ORG_W-1:0];
            end
            // [RQ3] chroma plane origin
            if (hit(regAddr, OFS_B2_CORG)) begin
                corgB2Pend_r <= merge({8'h00, corgB2Pend_r}, regWdata, regBe)
                                [ORG_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrlPend_r <= CTRL_RESET;
        end else if (regWr && hit(regAddr, OFS_CTRL)) begin
            ctrlPend_r <= merge(ctrlPend_r, regWdata, regBe) & CTRL_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            edgesPend_r  <= '0;
            hiscalPend_r <= '0;
        end else if (regWr) begin
            if (hit(regAddr, OFS_HEDGES)) begin
                edgesPend_r <= merge(edgesPend_r, regWdata, regBe) & 32'h07FF07FF;
            end
            // [RQ22] 5.14 factor in bits 20:2
            if (hit(regAddr, OFS_HISCAL)) begin
                hiscalPend_r <= merge(hiscalWord, regWdata, regBe)
                                [HISCAL_LSB +: HISCAL_W];
            end
        end
    end

    // Global control is not double buffered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            glob_r <= GLOB_RESET;
        end else if (regWr && hit(regAddr, OFS_GLOBAL)) begin
            glob_r <= merge(glob_r, regWdata, regBe) & GLOB_MASK;
        end
    end

    // ----------
    // Double buffer load
    // ----------
    // [RQ19] active copies load on the update pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            orgB1_r  <= '0;
            orgB2_r  <= '0;
            corgB2_r <= '0;
            ctrl_r   <= CTRL_RESET;
            edges_r  <= '0;
            hiscal_r <= '0;
        end else if (tif.updateStb) begin
            orgB1_r  <= orgB1Pend_r;
            orgB2_r  <= orgB2Pend_r;
            corgB2_r <= corgB2Pend_r;
            ctrl_r   <= ctrlPend_r;
            edges_r  <= edgesPend_r;
            hiscal_r <= hiscalPend_r;
        end
    end

    // ----------
    // Displayed buffer and field
    // ----------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dispSel_r <= SEL_A_F1;
        end else if (tif.updateStb) begin
            // [RQ15] hardware select follows video input
            if (ctrlPend_r[CB_FSELM]) begin
                dispSel_r <= ovsc_sel_t'({tif.vipBuf, tif.vipField});
            end else begin
                // [RQ16] software buffer and field
                dispSel_r <= ovsc_sel_t'(ctrlPend_r[CB_FSEL_LSB +: 2]);
            end
        end
    end

    // ----------
    // Fetch addresses for the shown buffer
    // ----------
    // [RQ1] first pixel address per field
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lumaOrg_r        <= '0;
            lumaOrgValid_r   <= 1'b0;
            chromaOrgValid_r <= 1'b0;
        end else begin
            case (dispSel_r)
                SEL_B_F1: begin
                    lumaOrg_r      <= orgB1_r;
                    lumaOrgValid_r <= 1'b1;
                end
                SEL_B_F2: begin
                    lumaOrg_r      <= orgB2_r;
                    lumaOrgValid_r <= 1'b1;
                end
                default: begin
                    lumaOrg_r      <= '0;
                    lumaOrgValid_r <= 1'b0;
                end
            endcase
            // [RQ3] chroma fetch only in planar mode
            chromaOrgValid_r <= ctrl_r[CB_PLANAR] && (dispSel_r == SEL_B_F2);
        end
    end

    // ----------
    // Interpolation qualifiers
    // ----------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hInterp_r <= 1'b0;
            vInterp_r <= 1'b0;
        end else begin
            // [RQ6] only when scale is not unity
            hInterp_r <= ctrl_r[CB_HFILT] && (hiscal_r != HISCAL_UNITY);
            // [RQ7] only while vertical scaling
            vInterp_r <= ctrl_r[CB_VFILT] && vertScaling;
        end
    end

    // ----------
    // Read back
    // ----------
    // [RQ20] counter shown in global word
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (hit(regAddr, OFS_CTRL)) begin
            rdata_nxt = ctrlPend_r;
        end else if (hit(regAddr, OFS_GLOBAL)) begin
            rdata_nxt = glob_r;
            rdata_nxt[VCNT_LSB +: VCNT_W] = tif.vCount;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_r   <= 32'h00000000;
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= regRd;
            if (regRd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // ----------
    // Outputs
    // ----------
    assign regRdata               = rdata_r;
    assign regRdValid             = rdValid_r;
    // [RQ4] scaler on or off
    assign scalerOn               = ctrl_r[CB_ENABLE];
    // [RQ5] start line parity per field
    assign firstFieldStartParity  = ctrl_r[CB_F1_PAR];
    assign secondFieldStartParity = ctrl_r[CB_F2_PAR];
    assign hInterp                = hInterp_r;
    assign vInterp                = vInterp_r;
    // [RQ8] fixed half weight
    assign hWeightFixed           = ctrl_r[CB_HFIX];
    assign hWeightFixedVal        = HALF_WEIGHT;
    // [RQ9] chroma upsampling
    assign chromaUpsample         = ctrl_r[CB_CUPS];
    // [RQ10] source format
    assign two_plane_format       = ctrl_r[CB_PLANAR];
    // [RQ11] dithering
    assign ditherOn               = ctrl_r[CB_DITHER];
    // [RQ12] descending fetch
    assign readDescending         = ctrl_r[CB_MIRROR];
    // [RQ13] chroma forced mid
    assign chromaForce            = ctrl_r[CB_BW];
    assign chromaForceVal         = CHROMA_MID;
    // [RQ14] window blanking
    assign blankWindow            = ctrl_r[CB_BLANK];
    assign hwFieldSelect          = ctrl_r[CB_FSELM];
    assign dispSel                = dispSel_r;
    // [RQ17] zoom and its interpolation
    assign zoom2x                 = glob_r[GB_ZOOM];
    assign zoom2xInterp           = glob_r[GB_ZOOM] & glob_r[GB_ZOOMF];
    // [RQ18] chroma order in planar mode
    assign chromaSwap             = glob_r[GB_CORDER] & ctrl_r[CB_PLANAR];
    assign lumaOrigin             = lumaOrg_r;
    assign lumaOriginValid        = lumaOrgValid_r;
    assign chromaOrigin           = corgB2_r;
    assign chromaOriginValid      = chromaOrgValid_r;
    assign winLeft                = edges_r[LEFT_LSB +: EDGE_W];
    assign winRight               = edges_r[RIGHT_LSB +: EDGE_W];
    assign hInvScale              = hiscal_r;
    assign vCountOut              = tif.vCount;

endmodule : ovsc_regs

// ---- core/ovsc_tim_if.sv ----
// Link between the register bank and its retrace timing unit
`timescale 1ns/1ps
interface ovsc_tim_if;
    import ovsc_pkg::*;
    logic                hupMode;   // Load at every line
    logic                updateStb; // Double buffer load pulse
    logic [VCNT_W-1:0]   vCount;    // Current vertical line
    logic                vipField;  // Video input field, synced
    logic                vipBuf;    // Video input buffer, synced
    modport tim (input hupMode, output updateStb, vCount, vipField, vipBuf);
    modport regs (output hupMode, input updateStb, vCount, vipField, vipBuf);
endinterface : ovsc_tim_if

// ---- core/ovsc_timing.sv ----
// Retrace timing: pin sync, vertical counter, double buffer load pulse
`timescale 1ns/1ps
module ovsc_timing
    import ovsc_pkg::*;
(
    input  wire logic ref_clk,     // 10 MHz clock
    input  wire logic rst,         // Async reset, high
    input  wire logic vsyncPin,    // Vertical retrace pin
    input  wire logic hsyncPin,    // Horizontal sync pin
    input  wire logic vipFieldPin, // Video input field pin
    input  wire logic vipBufPin,   // Video input buffer pin
    ovsc_tim_if.tim   tim          // Link to register bank
);

    // ----------
    // Two-stage synchronisers
    // ----------
    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic       vsDly_r;
    logic       hsDly_r;
    logic [VCNT_W-1:0] vCount_r;
    logic       vsEdge;
    logic       hsEdge;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r <= 4'h0;
            sync_r <= 4'h0;
        end else begin
            meta_r <= {vipBufPin, vipFieldPin, hsyncPin, vsyncPin};
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vsDly_r <= 1'b0;
            hsDly_r <= 1'b0;
        end else begin
            vsDly_r <= sync_r[0];
            hsDly_r <= sync_r[1];
        end
    end

    assign vsEdge = sync_r[0] & ~vsDly_r;
    assign hsEdge = sync_r[1] & ~hsDly_r;

    // ----------
    // Vertical counter
    // ----------
    // [RQ20] line position count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vCount_r <= '0;
        end else if (vsEdge) begin
            vCount_r <= '0;
        end else if (hsEdge) begin
            vCount_r <= vCount_r + 12'h001;
        end
    end

    // [RQ19] retrace or line load
    assign tim.updateStb = tim.hupMode ? hsEdge : vsEdge;
    assign tim.vCount    = vCount_r;
    assign tim.vipField  = sync_r[2];
    assign tim.vipBuf    = sync_r[3];

endmodule : ovsc_timing

// ---- tb/ovsc_regs_monitor.sv ----
// Port checks for the overlay scaler control register bank
`timescale 1ns/1ps
module ovsc_regs_monitor
    import ovsc_pkg::*;
(
    input wire logic                      ref_clk,           // Clock
    input wire logic                      rst,               // Async reset
    input wire logic [ovsc_pkg::ADDR_W-1:0] regAddr,         // Byte offset
    input wire logic                      regRd,             // Read strobe
    input wire logic [31:0]               regRdata,          // Read data
    input wire logic                      regRdValid,        // Read valid
    input wire logic                      vertScaling,       // Vertical scaling on
    input wire logic                      hInterp,           // Horizontal interp
    input wire logic                      vInterp,           // Vertical interp
    input wire logic [ovsc_pkg::HISCAL_W-1:0] hInvScale,     // Active scale
    input wire ovsc_pkg::ovsc_sel_t       dispSel,           // Shown buffer
    input wire logic                      lumaOriginValid,   // Luma origin valid
    input wire logic                      two_plane_format,  // Planar source
    input wire logic                      chromaOriginValid  // Chroma origin valid
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_rdCtl; regRd && regAddr == OFS_CTRL; endsequence
    sequence s_rdGlb; regRd && regAddr == OFS_GLOBAL; endsequence
    property p_rdv; regRd |=> regRdValid; endproperty
    a_rdv: assert property (p_rdv) else $error("read valid missing");
    property p_rdq; !regRd |=> !regRdValid; endproperty
    a_rdq: assert property (p_rdq) else $error("stray read valid");
    property p_ctlRsv; s_rdCtl |=> (regRdata & ~CTRL_MASK) == 32'h0; endproperty
    a_ctlRsv: assert property (p_ctlRsv) else $error("control reserved set");
    property p_glbRsv; s_rdGlb |=> (regRdata & 32'hF000FFE4) == 32'h0; endproperty
    a_glbRsv: assert property (p_glbRsv) else $error("global reserved set");
    property p_wo; regRd && regAddr == OFS_B1_ORG |=> regRdata == 32'h0; endproperty
    a_wo: assert property (p_wo) else $error("origin readable");
    property p_hUnity; $past(hInvScale) == HISCAL_UNITY |-> !hInterp; endproperty
    a_hUnity: assert property (p_hUnity) else $error("interp at unity");
    property p_vOff; !$past(vertScaling) |-> !vInterp; endproperty
    a_vOff: assert property (p_vOff) else $error("vertical interp unscaled");
    property p_luma; lumaOriginValid == $past(dispSel[1]); endproperty
    a_luma: assert property (p_luma) else $error("luma valid wrong");
    property p_chr; chromaOriginValid == $past(two_plane_format && dispSel == SEL_B_F2);
    endproperty
    a_chr: assert property (p_chr) else $error("chroma valid wrong");
endmodule : ovsc_regs_monitor

bind ovsc_regs ovsc_regs_monitor u_mon (.ref_clk, .rst, .regAddr, .regRd, .regRdata,
    .regRdValid, .vertScaling, .hInterp, .vInterp, .hInvScale, .dispSel, .lumaOriginValid,
    .two_plane_format, .chromaOriginValid);

// ---- tb/test_ovsc_regs.sv ----
// Directed bench for the overlay scaler control register bank
`timescale 1ns/1ps
module test_ovsc_regs;
    import ovsc_pkg::*;
    logic ref_clk = 0, rst = 1, regWr = 0, regRd = 0, vsyncPin = 0, hsyncPin = 0;
    logic vipFieldPin = 0, vipBufPin = 0, vertScaling = 0, regRdValid, lumaOriginValid;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [3:0] regBe = 4'hF;
    logic [31:0] regWdata = '0, regRdata;
    logic scalerOn, firstFieldStartParity, secondFieldStartParity, hInterp, vInterp;
    logic hWeightFixed, chromaUpsample, two_plane_format, ditherOn, readDescending;
    logic chromaForce, blankWindow, hwFieldSelect, zoom2x, zoom2xInterp, chromaSwap;
    logic chromaOriginValid;
    logic [13:0] hWeightFixedVal;
    logic [7:0] chromaForceVal;
    logic [ORG_W-1:0] lumaOrigin, chromaOrigin;
    logic [EDGE_W-1:0] winLeft, winRight;
    logic [HISCAL_W-1:0] hInvScale;
    logic [VCNT_W-1:0] vCountOut;
    ovsc_sel_t dispSel;
    int failures = 0, tests_run = 0;
    ovsc_regs DUT (.*);
    always #50 ref_clk = ~ref_clk;
    // ----------
    // Bus and pin helpers
    // ----------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask : cyc
    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
        cyc(1);
        regAddr = a; regWdata = d; regBe = b; regWr = 1;
        cyc(1);
        regWr = 0;
    endtask : wr
    task automatic rd(input logic [13:0] a, input logic [31:0] exp, input string what);
        cyc(1);
        regAddr = a; regRd = 1;
        cyc(1);
        regRd = 0;
        cmp(32'(regRdValid), 32'h1, "read valid");
        cmp(regRdata, exp, what);
    endtask : rd
    // Sync pulses long enough for the two-stage synchroniser
    task automatic vs;
        vsyncPin = 1; cyc(5); vsyncPin = 0; cyc(2);
    endtask : vs
    task automatic hs;
        hsyncPin = 1; cyc(5); hsyncPin = 0; cyc(2);
    endtask : hs
    function automatic logic [31:0] flags;
        return 32'({scalerOn, firstFieldStartParity, secondFieldStartParity, hWeightFixed,
            chromaUpsample, two_plane_format, ditherOn, readDescending, chromaForce,
            blankWindow, hwFieldSelect});
    endfunction : flags
    // ----------
    // Scenarios
    // ----------
    task automatic t_glob;
        wr(OFS_GLOBAL, 32'hFFFFFFFF);
        rd(OFS_GLOBAL, 32'h0000001B, "global");
        cmp(32'({zoom2x, zoom2xInterp, chromaSwap}), 32'h6, "zoom");
        wr(OFS_GLOBAL, 32'h00000001);
        cyc(1);
        cmp(32'({zoom2x, zoom2xInterp}), 32'h2, "zoom only");
        rd(14'h3D10, 32'h0, "unmapped");
        rd(OFS_B1_ORG, 32'h0, "write only");
        $display("test glob done");
    endtask : t_glob
    task automatic t_ctrl;
        wr(OFS_CTRL, 32'hFFFFFFFF);
        rd(OFS_CTRL, CTRL_MASK, "control");
        cmp(32'(scalerOn), 32'h0, "before load");
        vs;
        cmp(flags(), 32'h7FF, "flags on");
        cmp(32'({hWeightFixedVal, chromaForceVal}), {10'h0, HALF_WEIGHT, CHROMA_MID}, "fixed");
        wr(OFS_GLOBAL, 32'h00000008);
        cyc(1);
        cmp(32'(chromaSwap), 32'h1, "swap");
        wr(OFS_GLOBAL, 32'h0);
        wr(OFS_CTRL, 32'h0);
        vs;
        cmp(flags(), 32'h0, "flags off");
        $display("test ctrl done");
    endtask : t_ctrl
    task automatic t_sel;
        wr(OFS_B1_ORG, 32'hFF123450);
        wr(OFS_B2_ORG, 32'h00ABCDE8);
        wr(OFS_B2_CORG, 32'h0055AA00);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL, 32'h00020000 | (32'(i) << 25));
            vs;
            cmp(32'(dispSel), 32'(i), "field select");
            cmp(32'(lumaOrigin), i == 2 ? 32'h123450 : i == 3 ? 32'hABCDE8 : 32'h0, "luma");
            cmp(32'(chromaOriginValid), 32'(i == 3), "chroma valid");
        end
        cmp(32'(chromaOrigin), 32'h55AA00, "chroma origin");
        vipBufPin = 1; vipFieldPin = 1;
        wr(OFS_CTRL, 32'h01000000);
        vs;
        cmp(32'(dispSel), 32'h3, "hardware select");
        vipBufPin = 0; vipFieldPin = 0;
        $display("test sel done");
    endtask : t_sel
    task automatic t_edge;
        wr(OFS_HEDGES, 32'h00640320);
        wr(OFS_HISCAL, 32'h00010000);
        wr(OFS_CTRL, 32'h00000C00);
        vs;
        cmp(32'({winLeft, winRight}), {10'h0, 11'h064, 11'h320}, "edges");
        cmp(32'(hInvScale), 32'h4000, "unity scale");
        cmp(32'({hInterp, vInterp}), 32'h0, "no interp");
        vertScaling = 1;
        wr(OFS_HISCAL, 32'h00020000);
        wr(OFS_HEDGES, 32'hFFFFFFFF, 4'b0100);
        vs;
        cmp(32'({hInterp, vInterp}), 32'h3, "interp");
        cmp(32'(winLeft), 32'h0FF, "lane write");
        cmp(32'(hInvScale), 32'h8000, "half scale");
        vertScaling = 0;
        $display("test edge done");
    endtask : t_edge
    task automatic t_vcnt;
        repeat (5) hs;
        cmp(32'(vCountOut), 32'h5, "line count");
        rd(OFS_GLOBAL, 32'h00050000, "counter read");
        wr(OFS_GLOBAL, 32'h00000010);
        wr(OFS_CTRL, 32'h00000001);
        hs;
        cmp(32'(scalerOn), 32'h1, "line load");
        vs;
        cmp(32'(vCountOut), 32'h0, "retrace clear");
        $display("test vcnt done");
    endtask : t_vcnt
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        end_sim;
    end
    initial begin
        cyc(2);
        rst = 0;
        t_glob;
        t_ctrl;
        t_sel;
        t_edge;
        t_vcnt;
        end_sim;
    end
endmodule : test_ovsc_regs
